// file: shared/record_cmd_map.vh
// Record command constants for the node command interpreter
`ifndef RECORD_CMD_MAP_VH
`define RECORD_CMD_MAP_VH
`define REC_WRITE_PARAM 8'h42
`define REC_RESET_NODE 8'h43
`define REC_SELECT_NODE 8'h44
`define REC_STORE_PARAM 8'h45
`define REC_STORE_CFG 8'h46
`define REQ_INDEX 8'h01
`define REQ_SUBSLOT 8'h01
`define SLOT_SEG_ONE 8'h00
`define SLOT_SEG_TWO 8'h64
`define STORE_TRIGGER 8'h01
`define PARAM_MSB 3
`define ADDR_MSB 6
`define OP_PARAM 3'h1
`define OP_RESET 3'h2
`define OP_SELECT 3'h3
`define OP_STORE_PARAM 3'h4
`define OP_STORE_CFG 3'h5
`define RESP_STATUS_OK 8'h00
`define RESP_STATUS_NOK 8'h01
`endif

// file: verif/record_cmd_chk.sv
// Port checks for the record request interpreter
`timescale 1ns/10ps
`default_nettype none
module record_cmd_chk (
	input wire clk, sys_rst, req_valid, req_ready, req_write, rsp_valid,
	input wire request_result_flag, mst_valid, mst_done, mst_ok, mst_seg,
	input wire param_bit_zero, param_bit_one, param_bit_two, param_bit_three,
	input wire [7:0] req_slot, req_subslot, req_byte2, rsp_byte4,
	input wire [2:0] mst_op,
	input wire [6:0] mst_node
);
	logic [7:0] b2_r, sl_r;
	wire take = req_valid && req_ready;
	wire [3:0] pb = {param_bit_three, param_bit_two, param_bit_one,
		param_bit_zero};
	// Request fields as taken, for comparing against the command later
	always @(posedge clk) begin
		if (take) begin
			b2_r <= req_byte2;
			sl_r <= req_slot;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_param_bits: assert property (mst_valid && mst_op == 3'h1 |->
		pb == b2_r[3:0]) else $error("param bits wrong");
	a_read_time: assert property (take && !req_write |->
		##1 !mst_valid [*2] ##1 rsp_valid) else $error("read answer late");
	a_sel_node: assert property (mst_valid && mst_op == 3'h3 |->
		mst_node == b2_r[6:0]) else $error("selected node wrong");
	a_store_gate: assert property (mst_valid && mst_op > 3'h3 |->
		b2_r == 8'h01) else $error("store without trigger");
	a_seg_route: assert property (mst_valid |->
		mst_seg == (sl_r == 8'h64)) else $error("segment wrong");
	a_status_code: assert property (rsp_valid |->
		rsp_byte4 == (request_result_flag ? 8'h00 : 8'h01))
		else $error("status code wrong");
	a_ok_mirror: assert property (mst_done |-> ##2 rsp_valid &&
		request_result_flag == $past(mst_ok, 2)) else $error("status lost");
	a_bad_hdr: assert property (take && req_subslot != 8'h01 |->
		##1 !mst_valid [*3]) else $error("bad header sent on");
	c_param: cover property (mst_valid && mst_op == 3'h1);
	c_nok: cover property (rsp_valid && !request_result_flag);
	c_seg_two: cover property (mst_valid && mst_seg);
endmodule
bind record_cmd record_cmd_chk chk_u (.*);
`default_nettype wire

// file: verif/seg_master_model.sv
// Behavioural segment master answering interpreter commands
`timescale 1ns/10ps
`default_nettype none
module seg_master_model (
	input wire logic clk, sys_rst, mst_valid, mst_seg, slow, nok,
	input wire logic [2:0] mst_op,
	input wire logic [6:0] mst_node,
	output logic mst_done, mst_ok,
	output logic [7:0] mst_reply
);
	logic [3:0] cnt_r;
	initial {mst_done, mst_ok, mst_reply} = 10'h000;
	// Status and reply only mean something in the done cycle
	always @(posedge clk) begin
		mst_done <= 1'b0;
		mst_ok <= ~mst_ok;
		mst_reply <= ~mst_reply;
		if (sys_rst)
			cnt_r <= 4'h0;
		else if (mst_valid)
			cnt_r <= slow ? 4'h9 : 4'h1;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
		if (!sys_rst && !mst_valid && cnt_r == 4'h1) begin
			mst_done <= 1'b1;
			mst_ok <= ~nok;
			mst_reply <= {mst_seg, mst_op, mst_node[3:0]};
		end
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the record request interpreter
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_fail++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
	logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
	logic slow = 1'b0, nok = 1'b0;
	logic [7:0] req_index = 8'h01, req_subslot = 8'h01, req_slot = 8'h00;
	logic [7:0] req_record = 8'h00, req_byte2 = 8'h00;
	wire req_ready, rsp_valid, request_result_flag, mst_valid, mst_seg;
	wire mst_done, mst_ok, param_bit_zero, param_bit_one, param_bit_two;
	wire param_bit_three;
	wire [7:0] rsp_byte2, rsp_byte4, mst_reply;
	wire [2:0] mst_op;
	wire [6:0] mst_node;
	wire [3:0] pbits = {param_bit_three, param_bit_two, param_bit_one,
		param_bit_zero};
	int n_fail = 0, comparisons = 0, cyc = 0;
	record_cmd dut_u (.*);
	seg_master_model mdl_u (.*);
	always #4 clk = ~clk;
	task automatic xf(input logic w, s, input logic [7:0] rc, b2, e2,
		input logic ok);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_slot <= s ? 8'h64 : 8'h00;
		req_record <= rc;
		req_byte2 <= b2;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 40);
		if (n >= 40)
			n_fail++;
		`CHK("status", ok ? 8'h00 : 8'h01, rsp_byte4)
		`CHK("flag", ok, request_result_flag)
		`CHK("reply", e2, rsp_byte2)
	endtask
	task t_no_select;
		xf(1'b1, 1'b0, 8'h43, 8'h05, 8'h00, 1'b0);
		xf(1'b0, 1'b0, 8'h42, 8'h00, 8'h00, 1'b0);
		$display("test no_select done");
	endtask
	task t_seg_one;
		slow <= 1'b1;
		xf(1'b1, 1'b0, 8'h44, 8'h05, 8'h00, 1'b1);
		xf(1'b1, 1'b0, 8'h42, 8'hFB, 8'h00, 1'b1);
		`CHK("param", 4'hB, pbits)
		slow <= 1'b0;
		xf(1'b0, 1'b0, 8'h42, 8'h00, 8'h15, 1'b1);
		xf(1'b1, 1'b0, 8'h43, 8'h86, 8'h00, 1'b1);
		xf(1'b0, 1'b0, 8'h43, 8'h00, 8'h26, 1'b1);
		$display("test seg_one done");
	endtask
	task t_seg_two;
		nok <= 1'b1;
		xf(1'b1, 1'b1, 8'h44, 8'h09, 8'h00, 1'b0);
		nok <= 1'b0;
		xf(1'b1, 1'b1, 8'h42, 8'h03, 8'h00, 1'b0);
		xf(1'b1, 1'b1, 8'h44, 8'h09, 8'h00, 1'b1);
		xf(1'b1, 1'b1, 8'h42, 8'h03, 8'h00, 1'b1);
		xf(1'b0, 1'b1, 8'h42, 8'h00, 8'h99, 1'b1);
		$display("test seg_two done");
	endtask
	task t_store;
		xf(1'b1, 1'b0, 8'h45, 8'h01, 8'h00, 1'b1);
		xf(1'b1, 1'b0, 8'h45, 8'h02, 8'h00, 1'b0);
		xf(1'b1, 1'b1, 8'h46, 8'h01, 8'h00, 1'b1);
		req_subslot <= 8'h02;
		xf(1'b1, 1'b1, 8'h46, 8'h01, 8'h00, 1'b0);
		req_subslot <= 8'h01;
		$display("test store done");
	endtask
	task give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			give_verdict;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_no_select;
		t_seg_one;
		t_seg_two;
		t_store;
		give_verdict;
	end
endmodule
`default_nettype wire

// file: verilog/node_sel_mem.v
// Per-segment node selection and stored node replies
`timescale 1ns/10ps
`default_nettype none
module node_sel_mem (
	input wire clk,
	input wire sys_rst,
	input wire seg,
	input wire sel_we,
	input wire [6:0] sel_addr,
	input wire prm_we,
	input wire [7:0] prm_reply,
	input wire rst_we,
	input wire [7:0] rst_reply,
	output reg sel_valid,
	output reg [6:0] sel_node,
	output reg [7:0] prm_reply_q,
	output reg [7:0] rst_reply_q
);
	reg [1:0] valid_r;
	reg [6:0] node_r [0:1];
	reg [7:0] prm_r [0:1];
	reg [7:0] rsr_r [0:1];
	always @(posedge clk) begin
		if (sys_rst) begin
			valid_r <= 2'h0;
			node_r[0] <= 7'h00;
			node_r[1] <= 7'h00;
			prm_r[0] <= 8'h00;
			prm_r[1] <= 8'h00;
			rsr_r[0] <= 8'h00;
			rsr_r[1] <= 8'h00;
			sel_valid <= 1'b0;
			sel_node <= 7'h00;
			prm_reply_q <= 8'h00;
			rst_reply_q <= 8'h00;
		end else begin
			if (sel_we) begin
				valid_r[seg] <= 1'b1;
				node_r[seg] <= sel_addr;
			end
			if (prm_we)
				prm_r[seg] <= prm_reply;
			if (rst_we)
				rsr_r[seg] <= rst_reply;
			sel_valid <= valid_r[seg];
			sel_node <= node_r[seg];
			prm_reply_q <= prm_r[seg];
			rst_reply_q <= rsr_r[seg];
		end
	end
endmodule
`default_nettype wire

// file: verilog/record_cmd.v
// Record request interpreter for node parameter, reset, select and store
`timescale 1ns/10ps
`default_nettype none
`include "record_cmd_map.vh"
module record_cmd (
	input wire clk,
	input wire sys_rst,
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire [7:0] req_index,
	input wire [7:0] req_record,
	input wire [7:0] req_slot,
	input wire [7:0] req_subslot,
	input wire [7:0] req_byte2,
	output reg rsp_valid,
	output reg [7:0] rsp_byte2,
	output reg [7:0] rsp_byte4,
	output reg request_result_flag,
	output reg mst_valid,
	input wire mst_done,
	input wire mst_ok,
	input wire [7:0] mst_reply,
	output reg mst_seg,
	output reg [2:0] mst_op,
	output reg [6:0] mst_node,
	output reg param_bit_zero,
	output reg param_bit_one,
	output reg param_bit_two,
	output reg param_bit_three
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOOK = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_DONE = 2'h3;
	reg [1:0] state_r, state_nxt;
	reg wr_r, seg_r;
	reg [7:0] rec_r, dat_r;
	reg hdr_ok_r;
	reg ok_r;
	reg [7:0] b2_r;
	wire sel_valid;
	wire [6:0] sel_node;
	wire [7:0] prm_reply_q, rst_reply_q;
	wire sel_we, prm_we, rst_we;
	wire [7:0] b2_nxt;
	// Read side follows the request being taken, so LOOK sees its segment
	wire seg_rd = (state_r == ST_IDLE) ? (req_slot == `SLOT_SEG_TWO) :
		seg_r;
	assign req_ready = (state_r == ST_IDLE);
	node_sel_mem u_mem (
		.clk(clk),
		.sys_rst(sys_rst),
		.seg(seg_rd),
		.sel_we(sel_we),
		.sel_addr(dat_r[`ADDR_MSB:0]),
		.prm_we(prm_we),
		.prm_reply(mst_reply),
		.rst_we(rst_we),
		.rst_reply(mst_reply),
		.sel_valid(sel_valid),
		.sel_node(sel_node),
		.prm_reply_q(prm_reply_q),
		.rst_reply_q(rst_reply_q)
	);
	function slot_known;
		input [7:0] s;
		slot_known = (s == `SLOT_SEG_ONE) || (s == `SLOT_SEG_TWO);
	endfunction
	function [2:0] op_of;
		input [7:0] r;
		input [7:0] d;
		begin
			case (r)
			`REC_WRITE_PARAM: op_of = `OP_PARAM;
			`REC_RESET_NODE: op_of = `OP_RESET;
			`REC_SELECT_NODE: op_of = `OP_SELECT;
			`REC_STORE_PARAM: op_of = (d == `STORE_TRIGGER) ?
				`OP_STORE_PARAM : 3'h0;
			`REC_STORE_CFG: op_of = (d == `STORE_TRIGGER) ?
				`OP_STORE_CFG : 3'h0;
			default: op_of = 3'h0;
			endcase
		end
	endfunction
	wire [2:0] wr_op = op_of(rec_r, dat_r);
	wire need_sel = (wr_op == `OP_PARAM) || (wr_op == `OP_RESET);
	wire rd_ok = (rec_r == `REC_WRITE_PARAM) || (rec_r == `REC_RESET_NODE);
	wire go_master = wr_r && hdr_ok_r && (wr_op != 3'h0) &&
		!(need_sel && !sel_valid);
	assign sel_we = (state_r == ST_WAIT) && mst_done && mst_ok &&
		(mst_op == `OP_SELECT);
	assign prm_we = (state_r == ST_WAIT) && mst_done &&
		(mst_op == `OP_PARAM);
	assign rst_we = (state_r == ST_WAIT) && mst_done &&
		(mst_op == `OP_RESET);
	assign b2_nxt = (rec_r == `REC_WRITE_PARAM) ? prm_reply_q : rst_reply_q;
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: if (req_valid) state_nxt = ST_LOOK;
		ST_LOOK: state_nxt = go_master ? ST_WAIT : ST_DONE;
		ST_WAIT: if (mst_done) state_nxt = ST_DONE;
		ST_DONE: state_nxt = ST_IDLE;
		default: state_nxt = ST_IDLE;
		endcase
	end
	always @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			wr_r <= 1'b0;
			seg_r <= 1'b0;
			rec_r <= 8'h00;
			dat_r <= 8'h00;
			hdr_ok_r <= 1'b0;
			ok_r <= 1'b0;
			b2_r <= 8'h00;
			rsp_valid <= 1'b0;
			rsp_byte2 <= 8'h00;
			rsp_byte4 <= 8'h00;
			request_result_flag <= 1'b0;
			mst_valid <= 1'b0;
			mst_seg <= 1'b0;
			mst_op <= 3'h0;
			mst_node <= 7'h00;
			param_bit_zero <= 1'b0;
			param_bit_one <= 1'b0;
			param_bit_two <= 1'b0;
			param_bit_three <= 1'b0;
		end else begin
			state_r <= state_nxt;
			rsp_valid <= 1'b0;
			mst_valid <= 1'b0;
			if (state_r == ST_IDLE && req_valid) begin
				wr_r <= req_write;
				rec_r <= req_record;
				dat_r <= req_byte2;
				seg_r <= (req_slot == `SLOT_SEG_TWO);
				hdr_ok_r <= slot_known(req_slot) &&
					(req_index == `REQ_INDEX) &&
					(req_subslot == `REQ_SUBSLOT);
			end
			if (state_r == ST_LOOK) begin
				ok_r <= wr_r ? 1'b0 : (hdr_ok_r && rd_ok && sel_valid);
				b2_r <= (hdr_ok_r && rd_ok && sel_valid) ? b2_nxt : 8'h00;
				if (go_master) begin
					mst_valid <= 1'b1;
					mst_seg <= seg_r;
					mst_op <= wr_op;
					mst_node <= ((wr_op == `OP_SELECT) ||
						(wr_op == `OP_RESET)) ?
						dat_r[`ADDR_MSB:0] : sel_node;
					param_bit_zero <= dat_r[0];
					param_bit_one <= dat_r[1];
					param_bit_two <= dat_r[2];
					param_bit_three <= dat_r[`PARAM_MSB];
				end
			end
			if (state_r == ST_WAIT && mst_done)
				ok_r <= mst_ok;
			if (state_r == ST_DONE) begin
				rsp_valid <= 1'b1;
				rsp_byte2 <= wr_r ? 8'h00 : b2_r;
				rsp_byte4 <= ok_r ? `RESP_STATUS_OK : `RESP_STATUS_NOK;
				request_result_flag <= ok_r;
			end
		end
	end
endmodule
`default_nettype wire
